// ==== design/fadc_map.svh ====
// Offsets, field positions and timing counts of the charge integrator
`ifndef FADC_MAP_SVH
`define FADC_MAP_SVH

// ----------------------------------------------------------------------
// Data widths
// ----------------------------------------------------------------------
`define FCI_ADC_BITS    10
`define FCI_DIFF_BITS   11
`define FCI_SUM_BITS    17
`define FCI_WORD_BITS   64
`define FCI_TRIG_BITS   8

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define FCI_CLK_MHZ      100
`define FCI_SAMPLE_MHZ   40
`define FCI_LATENCY_NS   6400
`define FCI_PERIOD_NS    25
`define FCI_PIPE_CELLS   ((`FCI_LATENCY_NS / `FCI_PERIOD_NS) + 1)
`define FCI_SAMPLES      40

// ----------------------------------------------------------------------
// Event buffer word layout
// ----------------------------------------------------------------------
`define FCI_HDR_FLAG_BIT 63
`define FCI_TRIG_LSB     0
`define FCI_CHAN_LSB     32
`define FCI_CHAN_BITS    8
`define FCI_SUM_LSB      0

// ----------------------------------------------------------------------
// Buffer depths
// ----------------------------------------------------------------------
`define FCI_CHAN_DEPTH   4
`define FCI_GLOBAL_DEPTH 2048

`endif

// ==== design/fadc_pkg.sv ====
// Types shared by the charge integrator modules
`default_nettype none

package fadc_pkg;

	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_PED  = 6'h02,
		ST_SUM  = 6'h04,
		ST_CMP  = 6'h08,
		ST_HDR  = 6'h10,
		ST_MOVE = 6'h20
	} seq_state_e;

	typedef logic signed [16:0] charge_sum_t;

endpackage

`default_nettype wire

// ==== design/stream_if.sv ====
// Valid/ready stream carrier between the integrator's own modules
`default_nettype none

interface stream_if #(
	parameter int W = 8
);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;

	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

`default_nettype wire

// ==== design/word_fifo.sv ====
// First-in first-out store with valid/ready on both sides
`default_nettype none

module word_fifo #(
	parameter int WIDTH = 17,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic reset,
	// Fill side
	stream_if.snk     wr,
	// Drain side
	stream_if.src     rd
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wp_q;
	logic [AW-1:0]    wp_d;
	logic [AW-1:0]    rp_q;
	logic [AW-1:0]    rp_d;
	logic [AW:0]      cnt_q;
	logic [AW:0]      cnt_d;
	logic             push;
	logic             pop;

	// Honest full and empty straight from the occupancy count
	assign wr.ready = (cnt_q != (AW+1)'(DEPTH));
	assign rd.valid = (cnt_q != '0);
	assign rd.data  = mem[rp_q];
	assign push     = wr.valid && wr.ready;
	assign pop      = rd.valid && rd.ready;

	always_comb begin
		wp_d  = push ? wp_q + 1'b1 : wp_q;
		rp_d  = pop ? rp_q + 1'b1 : rp_q;
		cnt_d = cnt_q;
		if (push && !pop) begin
			cnt_d = cnt_q + 1'b1;
		end else if (pop && !push) begin
			cnt_d = cnt_q - 1'b1;
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
		end else begin
			wp_q  <= wp_d;
			rp_q  <= rp_d;
			cnt_q <= cnt_d;
		end
	end

	// Storage is not reset; the count alone defines emptiness
	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem[wp_q] <= wr.data;
		end
	end

endmodule

`default_nettype wire

// ==== design/sample_delay.sv ====
// Fixed-length delay line for one channel's converter samples
`default_nettype none

module sample_delay #(
	parameter int WIDTH = 10,
	parameter int CELLS = 257
) (
	// Clock and reset
	input  wire logic             clk_sys,
	input  wire logic             reset,
	// Sample stream
	input  wire logic             shift_en,
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] cells_q [CELLS];
	logic [WIDTH-1:0] cells_d [CELLS];

	// The oldest cell is simply overwritten: no trigger, no consumer
	always_comb begin
		cells_d = cells_q;
		if (shift_en) begin
			cells_d[0] = din;
			for (int i = 1; i < CELLS; i++) begin
				cells_d[i] = cells_q[i-1];
			end
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			for (int i = 0; i < CELLS; i++) begin
				cells_q[i] <= '0;
			end
		end else begin
			cells_q <= cells_d;
		end
	end

	assign dout = cells_q[CELLS-1];

endmodule

`default_nettype wire

// ==== design/fadc_charge_integrator.sv ====
// Charge integrator: delay lines, pedestal, sums, zero suppression, buffer
`include "fadc_map.svh"
`default_nettype none

module fadc_charge_integrator #(
	parameter int CHANNELS     = 8,
	parameter int GLOBAL_DEPTH = `FCI_GLOBAL_DEPTH,
	parameter int CHAN_DEPTH   = `FCI_CHAN_DEPTH
) (
	// Clock and reset
	input  wire logic                                 clk_sys,
	input  wire logic                                 reset,
	// Converters
	output logic                                      sample_strobe,
	input  wire logic [CHANNELS*`FCI_ADC_BITS-1:0]    adc_data,
	// Trigger system
	input  wire logic                                 level_one_accept,
	output logic                                      overflow_flag,
	output logic                                      busy,
	output logic      [`FCI_TRIG_BITS-1:0]            trigger_count,
	// Zero suppression level
	input  wire logic signed [`FCI_SUM_BITS-1:0]      threshold,
	// Readout
	output logic      [`FCI_WORD_BITS-1:0]            evt_data,
	output logic                                      evt_valid,
	input  wire logic                                 evt_ready
);
	localparam int SW = (CHANNELS > 1) ? $clog2(CHANNELS) : 1;

	// ------------------------------------------------------------------
	// Sample rate divider
	// ------------------------------------------------------------------
	// Fractional divider: 2 pulses in every 5 clocks average 40 MHz
	logic [7:0] phase_q;
	logic [7:0] phase_d;
	logic       smp_q;
	logic       smp_d;

	always_comb begin
		phase_d = phase_q + 8'(`FCI_SAMPLE_MHZ);
		smp_d   = 1'b0;
		if (phase_d >= 8'(`FCI_CLK_MHZ)) begin
			phase_d = phase_d - 8'(`FCI_CLK_MHZ);
			smp_d   = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			phase_q <= '0;
			smp_q   <= 1'b0;
		end else begin
			phase_q <= phase_d;
			smp_q   <= smp_d;
		end
	end

	assign sample_strobe = smp_q;

	// ------------------------------------------------------------------
	// Sequence state
	// ------------------------------------------------------------------
	fadc_pkg::seq_state_e          st_q;
	fadc_pkg::seq_state_e          st_d;
	logic [5:0]                    n_q;
	logic [5:0]                    n_d;
	logic [SW-1:0]                 sel_q;
	logic [SW-1:0]                 sel_d;
	logic [`FCI_TRIG_BITS-1:0]     cnt_q;
	logic [`FCI_TRIG_BITS-1:0]     cnt_d;
	logic [CHANNELS-1:0]           done_q;
	logic [CHANNELS-1:0]           done_d;
	logic                          ovf_q;
	logic                          ovf_d;

	// Per-channel views
	logic [`FCI_ADC_BITS-1:0]      pipe_end [CHANNELS];
	fadc_pkg::charge_sum_t         acc_q    [CHANNELS];
	logic [CHANNELS-1:0]           keep;
	logic [CHANNELS-1:0]           cw_valid;
	logic [CHANNELS-1:0]           cw_ready;
	logic [CHANNELS-1:0]           cr_valid;
	logic [CHANNELS-1:0]           cr_ready;
	logic [`FCI_SUM_BITS-1:0]      cr_data  [CHANNELS];
	logic                          cmp_ok;

	// Event buffer carriers
	stream_if #(.W(`FCI_WORD_BITS)) glob_in ();
	stream_if #(.W(`FCI_WORD_BITS)) glob_out ();

	// ------------------------------------------------------------------
	// Channel datapath
	// ------------------------------------------------------------------
	genvar c;
	generate
		for (c = 0; c < CHANNELS; c++) begin : g_ch
			logic [`FCI_ADC_BITS-1:0]        base_q;
			logic [`FCI_ADC_BITS-1:0]        base_d;
			fadc_pkg::charge_sum_t           acc_d;
			logic signed [`FCI_DIFF_BITS-1:0] diff;

			stream_if #(.W(`FCI_SUM_BITS)) ch_in ();
			stream_if #(.W(`FCI_SUM_BITS)) ch_out ();

			// Delay line keeps shifting whatever the sequence does
			sample_delay #(
				.WIDTH (`FCI_ADC_BITS),
				.CELLS (`FCI_PIPE_CELLS)
			) u_delay (
				.clk_sys  (clk_sys),
				.reset    (reset),
				.shift_en (smp_q),
				.din      (adc_data[c*`FCI_ADC_BITS +: `FCI_ADC_BITS]),
				.dout     (pipe_end[c])
			);

			assign diff = $signed({1'b0, pipe_end[c]})
			            - $signed({1'b0, base_q});

			always_comb begin
				base_d = base_q;
				acc_d  = acc_q[c];
				if (smp_q && st_q == fadc_pkg::ST_PED) begin
					base_d = pipe_end[c];
					acc_d  = '0;
				end else if (smp_q && st_q == fadc_pkg::ST_SUM) begin
					// Sign extension keeps 40 full-scale terms in range
					acc_d = acc_q[c] + {{(`FCI_SUM_BITS-`FCI_DIFF_BITS)
					        {diff[`FCI_DIFF_BITS-1]}}, diff};
				end
			end

			always_ff @(posedge clk_sys or posedge reset) begin
				if (reset) begin
					base_q   <= '0;
					acc_q[c] <= '0;
				end else begin
					base_q   <= base_d;
					acc_q[c] <= acc_d;
				end
			end

			assign keep[c]      = (acc_q[c] > threshold);
			assign ch_in.valid  = cw_valid[c];
			assign ch_in.data   = acc_q[c];
			assign cw_ready[c]  = ch_in.ready;
			assign cr_valid[c]  = ch_out.valid;
			assign cr_data[c]   = ch_out.data;
			assign ch_out.ready = cr_ready[c];

			word_fifo #(
				.WIDTH (`FCI_SUM_BITS),
				.DEPTH (CHAN_DEPTH)
			) u_chan_buf (
				.clk_sys (clk_sys),
				.reset   (reset),
				.wr      (ch_in),
				.rd      (ch_out)
			);

			// Survivor push during compare, once per event
			assign cw_valid[c] = (st_q == fadc_pkg::ST_CMP) && keep[c]
			                   && !done_q[c];
			// Drain only the selected channel, one word per clock
			assign cr_ready[c] = (st_q == fadc_pkg::ST_MOVE)
			                   && (sel_q == SW'(c)) && glob_in.ready;
		end
	endgenerate

	// Compare step ends once every survivor has found room
	always_comb begin
		cmp_ok = 1'b1;
		for (int i = 0; i < CHANNELS; i++) begin
			if (cw_valid[i] && !cw_ready[i]) begin
				cmp_ok = 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// Event buffer feed
	// ------------------------------------------------------------------
	always_comb begin
		glob_in.valid = 1'b0;
		glob_in.data  = '0;
		if (st_q == fadc_pkg::ST_HDR) begin
			glob_in.valid = 1'b1;
			glob_in.data[`FCI_HDR_FLAG_BIT] = 1'b1;
			glob_in.data[`FCI_TRIG_LSB +: `FCI_TRIG_BITS] = cnt_q;
		end else if (st_q == fadc_pkg::ST_MOVE) begin
			glob_in.valid = cr_valid[sel_q];
			glob_in.data[`FCI_CHAN_LSB +: `FCI_CHAN_BITS] =
				`FCI_CHAN_BITS'(sel_q);
			glob_in.data[`FCI_SUM_LSB +: 32] =
				{{(32-`FCI_SUM_BITS){cr_data[sel_q][`FCI_SUM_BITS-1]}},
				 cr_data[sel_q]};
		end
	end

	word_fifo #(
		.WIDTH (`FCI_WORD_BITS),
		.DEPTH (GLOBAL_DEPTH)
	) u_event_buf (
		.clk_sys (clk_sys),
		.reset   (reset),
		.wr      (glob_in),
		.rd      (glob_out)
	);

	assign evt_valid      = glob_out.valid;
	assign evt_data       = glob_out.data;
	assign glob_out.ready = evt_ready;

	// ------------------------------------------------------------------
	// Control sequence
	// ------------------------------------------------------------------
	// Triggers outside idle are ignored; the trigger system masks them
	always_comb begin
		st_d   = st_q;
		n_d    = n_q;
		sel_d  = sel_q;
		cnt_d  = cnt_q;
		done_d = done_q;
		ovf_d  = !glob_in.ready;
		case (st_q)
			fadc_pkg::ST_IDLE: begin
				if (level_one_accept) begin
					cnt_d = cnt_q + 1'b1;
					st_d  = fadc_pkg::ST_PED;
				end
			end
			fadc_pkg::ST_PED: begin
				if (smp_q) begin
					n_d  = '0;
					st_d = fadc_pkg::ST_SUM;
				end
			end
			fadc_pkg::ST_SUM: begin
				if (smp_q) begin
					n_d = n_q + 1'b1;
					if (n_q == 6'(`FCI_SAMPLES - 1)) begin
						done_d = '0;
						st_d   = fadc_pkg::ST_CMP;
					end
				end
			end
			fadc_pkg::ST_CMP: begin
				done_d = done_q | (cw_valid & cw_ready);
				if (cmp_ok) begin
					st_d = fadc_pkg::ST_HDR;
				end
			end
			fadc_pkg::ST_HDR: begin
				if (glob_in.ready) begin
					sel_d = '0;
					st_d  = fadc_pkg::ST_MOVE;
				end
			end
			fadc_pkg::ST_MOVE: begin
				if (!cr_valid[sel_q] || glob_in.ready) begin
					sel_d = sel_q + 1'b1;
					if (sel_q == SW'(CHANNELS - 1)) begin
						sel_d = '0;
						st_d  = fadc_pkg::ST_IDLE;
					end
				end
			end
			default: begin
				st_d = fadc_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			st_q   <= fadc_pkg::ST_IDLE;
			n_q    <= '0;
			sel_q  <= '0;
			cnt_q  <= '0;
			done_q <= '0;
			ovf_q  <= 1'b0;
		end else begin
			st_q   <= st_d;
			n_q    <= n_d;
			sel_q  <= sel_d;
			cnt_q  <= cnt_d;
			done_q <= done_d;
			ovf_q  <= ovf_d;
		end
	end

	assign overflow_flag = ovf_q;
	assign busy          = (st_q != fadc_pkg::ST_IDLE);
	assign trigger_count = cnt_q;

endmodule

`default_nettype wire

// ==== bench/fadc_charge_integrator_checker.sv ====
// Port assertions for the charge integrator
`default_nettype none

module fadc_charge_integrator_checker #(
	parameter int CHANNELS = 8
) (
	// Clock and reset
	input wire logic                   clk_sys,
	input wire logic                   reset,
	// Observed ports
	input wire logic                   sample_strobe,
	input wire logic [CHANNELS*10-1:0] adc_data,
	input wire logic                   level_one_accept,
	input wire logic                   overflow_flag,
	input wire logic                   busy,
	input wire logic [7:0]             trigger_count,
	input wire logic signed [16:0]     threshold,
	input wire logic [63:0]            evt_data,
	input wire logic                   evt_valid,
	input wire logic                   evt_ready
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);

	// ----
	// Busy length, saturating so long stalls cannot wrap
	// ----
	logic [7:0] busy_len_q;
	logic [7:0] busy_len_d;

	always_comb begin
		busy_len_d = busy ? busy_len_q + {7'h00, ~&busy_len_q} : 8'h00;
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset)
			busy_len_q <= 8'h00;
		else
			busy_len_q <= busy_len_d;
	end

	AST_TRIG_BUSY: assert property (level_one_accept && !busy |=> busy)
		else $error("busy did not rise after trigger");
	AST_TRIG_COUNT: assert property (level_one_accept && !busy |=>
		trigger_count == $past(trigger_count) + 8'h01)
		else $error("trigger count did not step by one");
	AST_IDLE_STAYS: assert property (!level_one_accept && !busy |=>
		!busy && $stable(trigger_count))
		else $error("sequence started without trigger");
	AST_BUSY_COUNT: assert property (busy |=> $stable(trigger_count))
		else $error("count moved during a sequence");
	AST_STROBE_RATE: assert property (sample_strobe |=>
		!sample_strobe ##[1:2] sample_strobe)
		else $error("sample strobe spacing off");
	AST_SEQ_LENGTH: assert property ($fell(busy) |-> busy_len_q >= 8'h64)
		else $error("sequence shorter than forty samples");
	AST_HOLD_WORD: assert property (evt_valid && !evt_ready |=>
		evt_valid && $stable(evt_data))
		else $error("head word changed without pop");
	// Flag lags the buffer by one clock, so a pop just before still clears it
	AST_OVF_HOLD: assert property (overflow_flag && !evt_ready &&
		!$past(evt_ready) |=> overflow_flag)
		else $error("overflow cleared without pop");
	AST_HDR_FORM: assert property (evt_valid && evt_data[63] |->
		evt_data[62:8] == 55'h0)
		else $error("header word malformed");
	AST_DATA_FORM: assert property (evt_valid && !evt_data[63] |->
		evt_data[62:40] == 23'h0 &&
		(evt_data[31:16] == 16'h0000 || evt_data[31:16] == 16'hFFFF))
		else $error("data word malformed");

	cover property (level_one_accept && !busy);
	cover property ($rose(overflow_flag));
	cover property (evt_valid && evt_ready && evt_data[63]);
endmodule

bind fadc_charge_integrator fadc_charge_integrator_checker #(
	.CHANNELS(CHANNELS)
) chk_i (
	.clk_sys(clk_sys), .reset(reset), .sample_strobe(sample_strobe),
	.adc_data(adc_data), .level_one_accept(level_one_accept),
	.overflow_flag(overflow_flag), .busy(busy),
	.trigger_count(trigger_count), .threshold(threshold),
	.evt_data(evt_data), .evt_valid(evt_valid), .evt_ready(evt_ready)
);

`default_nettype wire

// ==== bench/readout_model.sv ====
// Trigger source and readout master facing the integrator
`default_nettype none

module readout_model (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        reset,
	// Trigger side
	input  wire logic        busy,
	input  wire logic        overflow_flag,
	output logic             level_one_accept,
	// Readout side
	input  wire logic        stall,
	input  wire logic        fast,
	input  wire logic [63:0] evt_data,
	input  wire logic        evt_valid,
	output logic             evt_ready
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [63:0] got[$];
	logic        slow_q;

	initial begin
		level_one_accept = 1'b0;
		evt_ready = 1'b0;
		slow_q = 1'b0;
	end

	// Slow mode pops every other cycle to exercise back-pressure
	always @(negedge clk_sys) begin
		slow_q <= ~slow_q;
		evt_ready <= !stall && (fast || slow_q);
	end

	always @(posedge clk_sys) begin
		if (!reset && evt_valid && evt_ready)
			got.push_back(evt_data);
	end

	// Called at a falling edge; one-cycle pulse
	task automatic fire();
		while (busy || overflow_flag) @(negedge clk_sys);
		level_one_accept = 1'b1;
		@(negedge clk_sys);
		level_one_accept = 1'b0;
	endtask
endmodule

`default_nettype wire

// ==== bench/fadc_charge_integrator_test.sv ====
// Self-checking bench for the charge integrator
`default_nettype none

module fadc_charge_integrator_test;
	timeunit 1ns;
	timeprecision 1ns;

	localparam int CH = 8;

	logic               clk_sys;
	logic               reset;
	logic               sample_strobe;
	logic [CH*10-1:0]   adc_data;
	logic               level_one_accept;
	logic               overflow_flag;
	logic               busy;
	logic [7:0]         trigger_count;
	logic signed [16:0] threshold;
	logic [63:0]        evt_data;
	logic               evt_valid;
	logic               evt_ready;
	logic               stall;
	logic               fast;
	int                 n;
	int                 bad_count;
	int                 compares;
	logic [63:0]        exp_q[$];

	fadc_charge_integrator #(
		.CHANNELS(CH), .GLOBAL_DEPTH(8), .CHAN_DEPTH(4)
	) fadc_charge_integrator_i (
		.clk_sys(clk_sys), .reset(reset), .sample_strobe(sample_strobe),
		.adc_data(adc_data), .level_one_accept(level_one_accept),
		.overflow_flag(overflow_flag), .busy(busy),
		.trigger_count(trigger_count), .threshold(threshold),
		.evt_data(evt_data), .evt_valid(evt_valid), .evt_ready(evt_ready)
	);

	readout_model readout_model_i (
		.clk_sys(clk_sys), .reset(reset), .busy(busy),
		.overflow_flag(overflow_flag), .level_one_accept(level_one_accept),
		.stall(stall), .fast(fast), .evt_data(evt_data),
		.evt_valid(evt_valid), .evt_ready(evt_ready)
	);

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	// ----
	// Converter model: waveform indexed by strobe count
	// ----
	function automatic logic [9:0] samp(int c, int k);
		if (k < 0)
			return 10'h000;
		return 10'h040 + ((k % 64) < 20 ? 10'(c * 7) : 10'h000);
	endfunction

	always @(posedge clk_sys or posedge reset) begin
		if (reset)
			n <= 0;
		else if (sample_strobe)
			n <= n + 1;
	end

	always @(negedge clk_sys) begin
		for (int c = 0; c < CH; c++)
			adc_data[c*10+:10] <= samp(c, n);
	end

	// ----
	// Shared tasks
	// ----
	task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic conclude();
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Mode 1 sets the level equal to the last channel's sum
	task automatic run_event(int sel);
		logic [7:0] cnt;
		int         m;
		int         sums[CH];
		cnt = trigger_count;
		readout_model_i.fire();
		check("busy", busy, 1'b1);
		check("count", trigger_count, cnt + 8'h01);
		while (!sample_strobe) @(negedge clk_sys);
		m = n;
		for (int c = 0; c < CH; c++) begin
			sums[c] = -40 * int'(samp(c, m - 257));
			for (int i = 1; i <= 40; i++)
				sums[c] += int'(samp(c, m + i - 257));
		end
		threshold = sel == 0 ? 17'sh00000 : 17'sh1FC18;
		if (sel == 1)
			threshold = 17'(sums[CH-1]);
		exp_q.push_back({1'b1, 55'h0, cnt + 8'h01});
		for (int c = 0; c < CH; c++)
			if (sums[c] > int'(threshold))
				exp_q.push_back({24'h0, 8'(c), 32'(sums[c])});
	endtask

	task automatic drain();
		int k;
		k = 0;
		while ((busy || evt_valid) && k < 3000) begin
			@(negedge clk_sys);
			k++;
		end
		check("drained", k < 3000, 1'b1);
		check("words", readout_model_i.got.size(), exp_q.size());
		foreach (exp_q[i])
			check("word", readout_model_i.got[i], exp_q[i]);
		exp_q.delete();
		readout_model_i.got.delete();
	endtask

	// ----
	// Scenarios
	// ----
	task automatic test_reset_values();
		check("count", trigger_count, 8'h00);
		check("busy", busy, 1'b0);
		check("valid", evt_valid, 1'b0);
		check("overflow", overflow_flag, 1'b0);
		check("strobe", sample_strobe, 1'b0);
	endtask

	task automatic test_events();
		run_event(0);
		drain();
		fast = 1'b0;
		run_event(1);
		run_event(0);
		drain();
		fast = 1'b1;
	endtask

	task automatic test_overflow();
		int k;
		stall = 1'b1;
		run_event(2);
		k = 0;
		while (!overflow_flag && k < 400) begin
			@(negedge clk_sys);
			k++;
		end
		check("overflow", overflow_flag, 1'b1);
		check("stalled", busy, 1'b1);
		stall = 1'b0;
		drain();
		check("overflow", overflow_flag, 1'b0);
	endtask

	task automatic test_mid_reset();
		readout_model_i.fire();
		repeat (30) @(negedge clk_sys);
		reset = 1'b1;
		repeat (2) @(negedge clk_sys);
		test_reset_values();
		reset = 1'b0;
		@(negedge clk_sys);
		run_event(0);
		drain();
	endtask

	initial begin
		reset = 1'b1;
		stall = 1'b0;
		fast = 1'b1;
		threshold = 17'sh00000;
		adc_data = '0;
		bad_count = 0;
		compares = 0;
		repeat (16) @(negedge clk_sys);
		test_reset_values();
		reset = 1'b0;
		repeat (700) @(negedge clk_sys);
		test_events();
		test_overflow();
		test_mid_reset();
		conclude();
	end

	initial begin
		#200000;
		bad_count++;
		conclude();
	end
endmodule

`default_nettype wire
